// >>> sevr_status.sv
`timescale 1ns/100ps
module sevr_status #(
    parameter int NR = sevr_pkg::NUM_REG, // Number of 16-bit status registers
    parameter int EW = sevr_pkg::ERR_W, // Error code width
    parameter int EAW = sevr_pkg::ERR_AW // Error queue address width
) (
    input wire logic ref_clk, // 40 MHz clock
    input wire logic rst_n, // Async reset, active low
    input wire logic pon_pulse, // Power-on event
    input wire logic pon_clear_flag, // Power-on clear flag
    input wire logic dev_clear, // Device clear (DCL/SDC)
    input wire logic inst_reset, // Instrument reset or system preset
    input wire logic stat_preset, // Status preset
    input wire logic clear_status, // Clear-status command
    input wire logic [NR*16-1:0] cond_in, // Condition inputs, per register
    input wire logic [1:0] reg_sel, // Register selected for access
    input wire logic ena_wr, // Write enable part
    input wire logic ptr_wr, // Write positive filter
    input wire logic ntr_wr, // Write negative filter
    input wire logic [15:0] wr_data, // Write data
    input wire logic evt_rd, // Read event part (clears it)
    input wire logic stb_wr, // Write SRE/ESE/PPE group
    input wire logic [7:0] sre_wr_data, // Service request enable
    input wire logic [7:0] ese_wr_data, // Standard event enable
    input wire logic [7:0] ppe_wr_data, // Parallel poll enable
    input wire logic [7:0] esr_set, // Standard event sources
    input wire logic err_push, // Error condition pulse
    input wire logic [EW-1:0] err_code, // Error code
    input wire logic err_pop, // Read next error
    output logic [15:0] evt_out, // Event read data
    output logic [15:0] cond_out, // Condition read data
    output logic [15:0] ena_out, // Enable read data
    output logic [15:0] ptr_out, // Positive filter read data
    output logic [15:0] ntr_out, // Negative filter read data
    output logic [7:0] esr_out, // Standard event register
    output logic [7:0] stb_out, // Status byte
    output logic [7:0] sre_out, // Service request enable
    output logic [7:0] ese_out, // Standard event enable
    output logic [7:0] ppe_out, // Parallel poll enable
    output logic [EW-1:0] err_out, // Popped error code
    output logic err_valid, // Pulse: err_out updated
    output logic srq_out, // Service request
    output logic buf_flush, // Pulse: clear I/O buffers
    output logic func_reset // Pulse: reset functional settings
);
    localparam int DEPTH = 1 << EAW;
    logic pon_clr, pon_keep;
    logic [NR*16-1:0] cond_sync1, cond_sync2, cond_prev_reg;
    logic [NR*16-1:0] evt_reg, evt_next, ena_reg, ena_next;
    logic [NR*16-1:0] ptr_reg, ptr_next, ntr_reg, ntr_next;
    logic [7:0] esr_reg, esr_next, sre_reg, sre_next, ese_reg, ese_next, ppe_reg, ppe_next;
    logic [EAW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [EAW:0] cnt_reg, cnt_next;
    logic pop_pend_reg, pop_empty_reg;
    logic [EW-1:0] mem_rdata;
    logic q_clear, q_push, q_pop;

    assign pon_clr = pon_pulse & pon_clear_flag;
    assign pon_keep = pon_pulse & ~pon_clear_flag;

    // Condition inputs come from other logic domains
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_sync1 <= '0;
            cond_sync2 <= '0;
            cond_prev_reg <= '0;
        end else begin
            cond_sync1 <= cond_in;
            cond_sync2 <= cond_sync1;
            cond_prev_reg <= cond_sync2;
        end
    end

    always_comb begin
        evt_next = evt_reg;
        ena_next = ena_reg;
        ptr_next = ptr_reg;
        ntr_next = ntr_reg;
        for (int r = 0; r < NR; r++) begin
            if (evt_rd && reg_sel == 2'(r)) begin
                evt_next[r*16 +: 16] = sevr_pkg::ZERO16;
            end
            if (ena_wr && reg_sel == 2'(r)) begin
                ena_next[r*16 +: 16] = wr_data & sevr_pkg::ENA_MASK;
            end
            if (ptr_wr && reg_sel == 2'(r)) begin
                ptr_next[r*16 +: 16] = wr_data & sevr_pkg::ENA_MASK;
            end
            if (ntr_wr && reg_sel == 2'(r)) begin
                ntr_next[r*16 +: 16] = wr_data & sevr_pkg::ENA_MASK;
            end
            if (stat_preset) begin
                ena_next[r*16 +: 16] = (r == sevr_pkg::IDX_OPER) ?
                    sevr_pkg::ZERO16 : sevr_pkg::ONES16;
            end
            if (stat_preset || pon_clr) begin
                ptr_next[r*16 +: 16] = sevr_pkg::ONES16;
                ntr_next[r*16 +: 16] = sevr_pkg::ZERO16;
            end
            if (pon_clr) begin
                ena_next[r*16 +: 16] = sevr_pkg::ZERO16;
            end
            if (pon_clr || clear_status) begin
                evt_next[r*16 +: 16] = sevr_pkg::ZERO16;
            end
        end
        // Edge detection after clears so a same-cycle event still lands
        evt_next = evt_next | ((cond_sync2 & ~cond_prev_reg & ptr_reg)
            | (~cond_sync2 & cond_prev_reg & ntr_reg));
    end

    always_comb begin
        esr_next = esr_reg;
        sre_next = sre_reg;
        ese_next = ese_reg;
        ppe_next = ppe_reg;
        if (stb_wr) begin
            sre_next = sre_wr_data;
            ese_next = ese_wr_data;
            ppe_next = ppe_wr_data;
        end
        if (pon_clr || clear_status) begin
            esr_next = sevr_pkg::ZERO8;
        end
        if (pon_clr) begin
            sre_next = sevr_pkg::ZERO8;
            ese_next = sevr_pkg::ZERO8;
            ppe_next = sevr_pkg::ZERO8;
        end
        esr_next = esr_next | esr_set;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_reg <= '0;
            ena_reg <= '0;
            ptr_reg <= {NR{sevr_pkg::ONES16}};
            ntr_reg <= '0;
            esr_reg <= '0;
            sre_reg <= '0;
            ese_reg <= '0;
            ppe_reg <= '0;
        end else begin
            evt_reg <= evt_next;
            ena_reg <= ena_next;
            ptr_reg <= ptr_next;
            ntr_reg <= ntr_next;
            esr_reg <= esr_next;
            sre_reg <= sre_next;
            ese_reg <= ese_next;
            ppe_reg <= ppe_next;
        end
    end

    // Error queue; a full queue drops new entries rather than overwrite old ones
    assign q_clear = pon_pulse | clear_status;
    assign q_push = err_push && (cnt_reg != (EAW+1)'(DEPTH)) && !q_clear;
    assign q_pop = err_pop && (cnt_reg != '0) && !q_clear;

    always_comb begin
        wp_next = wp_reg;
        rp_next = rp_reg;
        cnt_next = cnt_reg;
        if (q_clear) begin
            wp_next = '0;
            rp_next = '0;
            cnt_next = '0;
        end else begin
            if (q_push) begin
                wp_next = wp_reg + 1'b1;
            end
            if (q_pop) begin
                rp_next = rp_reg + 1'b1;
            end
            cnt_next = cnt_reg + (EAW+1)'(q_push) - (EAW+1)'(q_pop);
        end
    end

    sevr_err_mem #(.W(EW), .AW(EAW)) u_mem (
        .ref_clk(ref_clk),
        .we(q_push),
        .waddr(wp_reg),
        .wdata(err_code),
        .raddr(rp_reg),
        .rdata(mem_rdata)
    );

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            pop_pend_reg <= 1'b0;
            pop_empty_reg <= 1'b0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            pop_pend_reg <= err_pop;
            pop_empty_reg <= err_pop && !q_pop;
        end
    end

    // Output registers
    logic [15:0] evt_sel, cond_sel, ena_sel, ptr_sel, ntr_sel;
    logic [7:0] stb_next;
    logic [NR-1:0] summ;
    always_comb begin
        evt_sel = sevr_pkg::ZERO16;
        cond_sel = sevr_pkg::ZERO16;
        ena_sel = sevr_pkg::ZERO16;
        ptr_sel = sevr_pkg::ZERO16;
        ntr_sel = sevr_pkg::ZERO16;
        for (int r = 0; r < NR; r++) begin
            summ[r] = |(evt_reg[r*16 +: 16] & ena_reg[r*16 +: 16]);
            if (reg_sel == 2'(r)) begin
                evt_sel = evt_reg[r*16 +: 16];
                cond_sel = cond_sync2[r*16 +: 16] & sevr_pkg::ENA_MASK;
                ena_sel = ena_reg[r*16 +: 16];
                ptr_sel = ptr_reg[r*16 +: 16];
                ntr_sel = ntr_reg[r*16 +: 16];
            end
        end
        stb_next = sevr_pkg::ZERO8;
        stb_next[sevr_pkg::STB_QUE] = (cnt_reg != '0);
        stb_next[sevr_pkg::STB_LAST] = summ[NR-1];
        stb_next[sevr_pkg::STB_ESB] = |(esr_reg & ese_reg);
        stb_next[sevr_pkg::STB_OPER] = summ[sevr_pkg::IDX_OPER];
        stb_next[sevr_pkg::STB_RQS] = |(stb_next & sre_reg);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_out <= '0;
            cond_out <= '0;
            ena_out <= '0;
            ptr_out <= '0;
            ntr_out <= '0;
            esr_out <= '0;
            stb_out <= '0;
            sre_out <= '0;
            ese_out <= '0;
            ppe_out <= '0;
            err_out <= '0;
            err_valid <= 1'b0;
            srq_out <= 1'b0;
            buf_flush <= 1'b0;
            func_reset <= 1'b0;
        end else begin
            evt_out <= evt_sel;
            cond_out <= cond_sel;
            ena_out <= ena_sel;
            ptr_out <= ptr_sel;
            ntr_out <= ntr_sel;
            esr_out <= esr_reg;
            stb_out <= stb_next;
            sre_out <= sre_reg;
            ese_out <= ese_reg;
            ppe_out <= ppe_reg;
            // Popped code stands until the next pop instead of tracking the memory
            err_out <= !pop_pend_reg ? err_out
                : (pop_empty_reg ? sevr_pkg::NO_ERROR_CODE : mem_rdata);
            err_valid <= pop_pend_reg;
            srq_out <= stb_next[sevr_pkg::STB_RQS];
            buf_flush <= pon_pulse | dev_clear;
            func_reset <= inst_reset;
        end
    end

    AST_PTR_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cond_sync2[0] && !cond_prev_reg[0] && ptr_reg[0]) |=> evt_reg[0])
        else $error("rising edge lost");
    AST_NTR_EVENT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!cond_sync2[0] && cond_prev_reg[0] && ntr_reg[0]) |=> evt_reg[0])
        else $error("falling edge lost");
    AST_NO_FILTER: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!evt_reg[0] && !ptr_reg[0] && !ntr_reg[0]) |=> !evt_reg[0])
        else $error("event set with filters off");
    AST_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (evt_reg[1] && !evt_rd && !clear_status && !pon_clr) |=> evt_reg[1])
        else $error("event bit dropped");
    AST_RD_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (evt_rd && reg_sel == 2'd0 && cond_sync2 == cond_prev_reg)
        |=> evt_reg[15:0] == 16'h0000)
        else $error("event not cleared by read");
    AST_ENA_MSB: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !ena_reg[15] && !ptr_reg[15] && !ntr_reg[15])
        else $error("msb set");
    AST_PRESET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (stat_preset && !ena_wr && !pon_clr) |=> ena_reg[15:0] == 16'h0000
        && ena_reg[31:16] == 16'h7FFF)
        else $error("preset enable wrong");
    AST_EMPTY_POP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (err_pop && cnt_reg == '0) |-> ##2 (err_valid && err_out == 16'h0000))
        else $error("empty pop not zero");
    AST_CLS_QUEUE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clear_status |=> cnt_reg == '0)
        else $error("queue not cleared");
    AST_DCL_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (dev_clear && !pon_pulse && !clear_status && !err_pop)
        |=> cnt_reg >= $past(cnt_reg))
        else $error("device clear touched queue");
endmodule : sevr_status

// >>> sevr_pkg.sv
package sevr_pkg;
    localparam int STAT_W = 16;
    localparam int BYTE_W = 8;
    localparam int ERR_W = 16;
    localparam int ERR_DEPTH = 8;
    localparam int ERR_AW = 3;
    localparam logic [15:0] ENA_MASK = 16'h7FFF;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] ONES16 = 16'h7FFF;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [15:0] NO_ERROR_CODE = 16'h0000;
    localparam int NUM_REG = 3;
    localparam int IDX_OPER = 0;
    localparam int STB_QUE = 2;
    localparam int STB_LAST = 3;
    localparam int STB_ESB = 5;
    localparam int STB_RQS = 6;
    localparam int STB_OPER = 7;
endpackage : sevr_pkg

// >>> sevr_err_mem.sv
`timescale 1ns/100ps
module sevr_err_mem #(
    parameter int W = 16, // Entry width
    parameter int AW = 3 // Address width
) (
    input wire logic ref_clk, // Clock
    input wire logic we, // Write strobe
    input wire logic [AW-1:0] waddr, // Write address
    input wire logic [W-1:0] wdata, // Write data
    input wire logic [AW-1:0] raddr, // Read address
    output logic [W-1:0] rdata // Registered read data
);
    logic [W-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : sevr_err_mem

// >>> sevr_ctrl_model.sv
`timescale 1ns/100ps
module sevr_ctrl_model (
    input wire logic ref_clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic srq_in, // Service request from the device
    input wire logic init_req, // Bench asks for an instrument reset
    input wire logic pop_req, // Bench asks for one error read
    output logic inst_reset, // Instrument reset pulse
    output logic err_pop // Error read pulse
);
    logic started_reg;
    logic srq_seen_reg;
    logic srq_rise;
    assign srq_rise = srq_in && !srq_seen_reg;
    // Falling-edge launch keeps requests clear of the sampling edge
    always @(negedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            started_reg <= 1'b0;
            srq_seen_reg <= 1'b0;
            inst_reset <= 1'b0;
            err_pop <= 1'b0;
        end else begin
            started_reg <= 1'b1;
            srq_seen_reg <= srq_in;
            inst_reset <= !started_reg || init_req;
            // A query never leaves in the same cycle as a setting
            err_pop <= started_reg && !init_req && (pop_req || srq_rise);
        end
    end
endmodule : sevr_ctrl_model

// >>> status_event_reset_logic_bench.sv
`timescale 1ns/100ps
module status_event_reset_logic_bench;
    localparam int PON = 0, DCL = 1, INI = 2, SPR = 3, CLS = 4, ENW = 5;
    localparam int PTW = 6, NTW = 7, EVR = 8, STW = 9, PSH = 10, POP = 11;
    typedef struct packed {logic [15:0] p, n, a, b, e, r;} sevr_row_s;
    // Filters, old and new condition, events after the edge and after reverting
    sevr_row_s rows [5] = '{
        '{16'h7FFF, 16'h0000, 16'h0000, 16'h00FF, 16'h00FF, 16'h00FF},
        '{16'h7FFF, 16'h0000, 16'h00FF, 16'h0000, 16'h0000, 16'h00FF},
        '{16'h0000, 16'h7FFF, 16'h00FF, 16'h0000, 16'h00FF, 16'h00FF},
        '{16'hFFFF, 16'hFFFF, 16'h0F0F, 16'h00FF, 16'h0FF0, 16'h0FF0},
        '{16'h0000, 16'h0000, 16'h0000, 16'h00FF, 16'h0000, 16'h0000}};
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pon_flag = 1'b1;
    logic [11:0] pl = 12'h000;
    logic [47:0] cond = 48'h000000000000;
    logic [1:0] sel = 2'h0;
    logic [15:0] wd = 16'h0000, ecode = 16'h0000;
    logic [7:0] sre_d = 8'h00, ese_d = 8'h00, ppe_d = 8'h00, esr_s = 8'h00;
    logic [15:0] evt_o, cond_o, ena_o, ptr_o, ntr_o, err_o;
    logic [7:0] esr_o, stb_o, sre_o, ese_o, ppe_o;
    logic err_v, srq, flush, freset, inst_rst, pop;
    int n_fail = 0, num_checks = 0, n_flush = 0, n_func = 0, cycles = 0, f0, g0;
    always #12.5 ref_clk = ~ref_clk;
    sevr_status dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .pon_pulse(pl[PON]),
        .pon_clear_flag(pon_flag), .dev_clear(pl[DCL]), .inst_reset(inst_rst),
        .stat_preset(pl[SPR]), .clear_status(pl[CLS]), .cond_in(cond), .reg_sel(sel),
        .ena_wr(pl[ENW]), .ptr_wr(pl[PTW]), .ntr_wr(pl[NTW]), .wr_data(wd), .evt_rd(pl[EVR]),
        .stb_wr(pl[STW]), .sre_wr_data(sre_d), .ese_wr_data(ese_d), .ppe_wr_data(ppe_d),
        .esr_set(esr_s), .err_push(pl[PSH]), .err_code(ecode), .err_pop(pop),
        .evt_out(evt_o), .cond_out(cond_o), .ena_out(ena_o), .ptr_out(ptr_o),
        .ntr_out(ntr_o), .esr_out(esr_o), .stb_out(stb_o), .sre_out(sre_o), .ese_out(ese_o),
        .ppe_out(ppe_o), .err_out(err_o), .err_valid(err_v), .srq_out(srq),
        .buf_flush(flush), .func_reset(freset));
    sevr_ctrl_model ctrl_u (.ref_clk(ref_clk), .rst_n(rst_n), .srq_in(srq),
        .init_req(pl[INI]), .pop_req(pl[POP]), .inst_reset(inst_rst), .err_pop(pop));
    task automatic final_report();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // Pulse counters and hang guard
    always @(posedge ref_clk) begin
        cycles++;
        n_flush += (flush === 1'b1);
        n_func += (freset === 1'b1);
        if (cycles == 5000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wt
    // Trailing idle cycle so the same strobe is never set and cleared in one step
    task automatic pulse(input int b);
        pl[b] <= 1'b1;
        wt(1);
        pl[b] <= 1'b0;
        wt(1);
    endtask : pulse
    task automatic wr(input int b, input logic [15:0] d);
        wd <= d;
        pulse(b);
    endtask : wr
    task automatic rs(input logic [1:0] s);
        sel <= s;
        wt(3);
    endtask : rs
    task automatic push(input logic [15:0] c);
        ecode <= c;
        pulse(PSH);
    endtask : push
    task automatic ev_chk(input logic [15:0] exp);
        int i;
        i = 0;
        while (err_v !== 1'b1 && i < 12) begin
            wt(1);
            i++;
        end
        chk({15'h0000, err_v}, 16'h0001);
        chk(err_o, exp);
    endtask : ev_chk
    task automatic pop_chk(input logic [15:0] exp);
        pulse(POP);
        ev_chk(exp);
    endtask : pop_chk
    initial begin
        wt(6);
        rst_n <= 1'b1;
        wt(4);
        pulse(PON);
        foreach (rows[i]) begin
            cond[15:0] <= rows[i].a;
            wr(PTW, rows[i].p);
            wr(NTW, rows[i].n);
            wt(5);
            pulse(EVR);
            cond[15:0] <= rows[i].b;
            wt(6);
            chk(evt_o, rows[i].e);
            chk(cond_o, rows[i].b);
            chk(ptr_o, rows[i].p & 16'h7FFF);
            chk(ntr_o, rows[i].n & 16'h7FFF);
            cond[15:0] <= rows[i].a;
            wt(6);
            chk(evt_o, rows[i].r);
            pulse(EVR);
            chk(evt_o, 16'h0000);
        end
        wr(ENW, 16'hFFFF);
        wt(1);
        chk(ena_o, 16'h7FFF);
        sre_d <= 8'h20;
        ese_d <= 8'h01;
        ppe_d <= 8'h5A;
        pulse(STW);
        push(16'hA001);
        push(16'hB002);
        esr_s <= 8'h01;
        wt(1);
        esr_s <= 8'h00;
        ev_chk(16'hA001);
        chk({15'h0000, srq}, 16'h0001);
        chk({8'h00, stb_o}, 16'h0064);
        pop_chk(16'hB002);
        pop_chk(16'h0000);
        wr(PTW, 16'h7FFF);
        cond[15:0] <= 16'h0003;
        rs(2'h1);
        wr(ENW, 16'h1234);
        wr(PTW, 16'h0001);
        wr(NTW, 16'h0F0F);
        push(16'hC003);
        f0 = n_flush;
        g0 = n_func;
        pulse(DCL);
        pulse(INI);
        rs(2'h0);
        chk(16'(n_flush - f0), 16'h0001);
        chk(16'(n_func - g0), 16'h0001);
        chk(evt_o, 16'h0003);
        chk({8'h00, esr_o}, 16'h0001);
        chk({8'h00, stb_o}, 16'h00E4);
        pulse(SPR);
        chk(ena_o, 16'h0000);
        chk(evt_o, 16'h0003);
        rs(2'h1);
        chk(ena_o, 16'h7FFF);
        chk(ptr_o, 16'h7FFF);
        chk(ntr_o, 16'h0000);
        rs(2'h0);
        pulse(CLS);
        chk(evt_o, 16'h0000);
        chk({esr_o, sre_o}, 16'h0020);
        chk(16'(n_flush - f0), 16'h0001);
        pop_chk(16'h0000);
        rs(2'h1);
        wr(PTW, 16'h0001);
        push(16'hD004);
        pon_flag <= 1'b0;
        pulse(PON);
        chk(ptr_o, 16'h0001);
        chk({ese_o, sre_o}, 16'h0120);
        chk(16'(n_flush - f0), 16'h0002);
        pop_chk(16'h0000);
        push(16'hE005);
        esr_s <= 8'h80;
        wt(1);
        esr_s <= 8'h00;
        pon_flag <= 1'b1;
        pulse(PON);
        chk(ptr_o, 16'h7FFF);
        chk(ena_o, 16'h0000);
        chk({sre_o, ese_o}, 16'h0000);
        chk({ppe_o, esr_o}, 16'h0000);
        pop_chk(16'h0000);
        // Last register summarises into the status byte on its own
        rs(2'h2);
        wr(ENW, 16'h0010);
        cond[47:32] <= 16'h0010;
        wt(6);
        chk(evt_o, 16'h0010);
        chk({8'h00, stb_o}, 16'h0008);
        // Mid-run reset: outputs drop to zero, filters come back preset
        rst_n <= 1'b0;
        wt(2);
        chk(ptr_o, 16'h0000);
        rst_n <= 1'b1;
        wt(3);
        chk(ptr_o, 16'h7FFF);
        final_report();
    end
endmodule : status_event_reset_logic_bench
